//--- common/rmc_pkg.sv
// package for the region monitor control block: register map, field layout, reset values
// assumes a 32-bit apb slave port at one register word per offset
package rmc_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] CTRL_OFFSET = 8'h04;   // monitor_control, write-only
  localparam logic [7:0] STATUS_OFFSET = 8'h08; // read-back of block state

  // ****************************************
  // control word fields
  // ****************************************
  localparam int WATCH_ON_LSB = 12;   // region_watch_on[3:0]
  localparam int WATCH_OFF_LSB = 8;   // region_watch_off[3:0]
  localparam int RECOMP_LSB = 4;      // digest_recompute[3:0]
  localparam int START_BIT = 0;       // monitor start
  localparam int STOP_BIT = 1;        // monitor stop
  localparam int SOFT_RST_BIT = 2;    // soft_reset_cmd

  // ****************************************
  // status word fields
  // ****************************************
  localparam int ST_WATCH_LSB = 0;    // per-region watch state
  localparam int ST_RUN_BIT = 4;      // monitor running
  localparam int ST_PEND_LSB = 8;     // recompute pending per region

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [3:0] WATCH_RESET = 4'hF;  // every region watched
  localparam logic RUN_RESET = 1'b0;          // monitor idle until started

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {RMC_IDLE, RMC_ACCESS} rmc_phase_t;

  typedef struct packed {
    rmc_phase_t phase;        // apb answer phase
    logic [3:0] watch;        // per-region monitoring enabled
    logic run;                // monitor started
    logic [3:0] recomp;       // one-cycle recompute pulses
    logic [3:0] pend;         // sticky record of honoured recomputes
    logic soft_rst;           // one-cycle internal reset pulse
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } rmc_state_t;

endpackage : rmc_pkg

//--- design/rmc_top.sv
// region monitor control: apb command register for an integrity-check monitor
// assumes a single clock domain and an apb master that holds requests until pready
//
// Notes on behaviour
// [R1] writing one to region_watch_on enables region
// [R2] writing one to region_watch_off disables region
// [R3] writing one to digest_recompute requests fresh digest
// [R4] recompute honoured only while region disabled
// [R5] after reset all regions are watched
// [R6] low bits start, stop, soft-reset the monitor
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
module rmc_top (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic pready_o,
  output logic pslverr_o,
  output logic [31:0] prdata_o,
  output logic [3:0] region_watch_o,     // per-region monitoring active
  output logic monitor_run_o,            // monitor running
  output logic [3:0] digest_recompute_o, // one-cycle recompute request per region
  output logic soft_reset_o              // one-cycle internal reset pulse
);

  // ****************************************
  // state
  // ****************************************
  rmc_pkg::rmc_state_t state_reg; // all registered state
  rmc_pkg::rmc_state_t state_next; // next value of it

  // field extract used for each four-bit command group
  function automatic logic [3:0] field4(input logic [31:0] w, input int lsb);
    field4 = w[lsb +: 4];
  endfunction : field4

  // ****************************************
  // next state
  // ****************************************
  // apb answers one cycle after setup: setup -> access with pready high
  always_comb begin
    logic wr_ctrl;
    logic [3:0] on_bits;
    logic [3:0] off_bits;
    logic [3:0] rc_bits;
    logic [3:0] watch_now;
    wr_ctrl = 1'b0;
    on_bits = 4'h0;
    off_bits = 4'h0;
    rc_bits = 4'h0;
    watch_now = 4'h0;
    state_next = state_reg;
    // pulses last only one cycle
    state_next.recomp = 4'h0;
    state_next.soft_rst = 1'b0;
    state_next.pready = 1'b0;
    state_next.pslverr = 1'b0;
    case (state_reg.phase)
      rmc_pkg::RMC_IDLE: begin
        // setup seen: answer in the next (access) cycle
        if (psel_i && !penable_i) begin
          state_next.phase = rmc_pkg::RMC_ACCESS;
          state_next.pready = 1'b1;
          state_next.prdata = 32'h0000_0000;
          if (paddr_i == rmc_pkg::STATUS_OFFSET && !pwrite_i) begin
            state_next.prdata[rmc_pkg::ST_WATCH_LSB +: 4] = state_reg.watch;
            state_next.prdata[rmc_pkg::ST_RUN_BIT] = state_reg.run;
            state_next.prdata[rmc_pkg::ST_PEND_LSB +: 4] = state_reg.pend;
          end else if (paddr_i == rmc_pkg::CTRL_OFFSET && pwrite_i) begin
            state_next.pslverr = 1'b0;
          end else if (paddr_i == rmc_pkg::CTRL_OFFSET) begin
            // write-only register reads as zero, no error
            state_next.pslverr = 1'b0;
          end else begin
            // unmapped address or write to the status word
            state_next.pslverr = 1'b1;
          end
        end
      end
      rmc_pkg::RMC_ACCESS: begin
        // the write takes effect at the edge that samples pready high
        state_next.phase = rmc_pkg::RMC_IDLE;
        wr_ctrl = psel_i && penable_i && pwrite_i && (paddr_i == rmc_pkg::CTRL_OFFSET);
      end
      default: begin
        state_next.phase = rmc_pkg::RMC_IDLE;
      end
    endcase
    if (wr_ctrl) begin
      on_bits = field4(pwdata_i, rmc_pkg::WATCH_ON_LSB);
      off_bits = field4(pwdata_i, rmc_pkg::WATCH_OFF_LSB);
      rc_bits = field4(pwdata_i, rmc_pkg::RECOMP_LSB);
      // [R4] gate on watch state before write
      // recompute checks the state held before this write, so software must
      // have disabled the region in an earlier write
      watch_now = state_reg.watch;
      // [R3] recompute pulse issued
      state_next.recomp = rc_bits & ~watch_now;
      state_next.pend = state_reg.pend | (rc_bits & ~watch_now);
      // [R2] disable selected regions
      state_next.watch = state_reg.watch & ~off_bits;
      // [R1] enable selected regions, enable wins
      state_next.watch = state_next.watch | on_bits;
      // [R6] start and stop commands
      if (pwdata_i[rmc_pkg::START_BIT]) begin
        state_next.run = 1'b1;
      end
      if (pwdata_i[rmc_pkg::STOP_BIT]) begin
        state_next.run = 1'b0;
      end
      // [R6] soft reset returns run, watch and pend to reset values
      if (pwdata_i[rmc_pkg::SOFT_RST_BIT]) begin
        state_next.soft_rst = 1'b1;
        state_next.run = rmc_pkg::RUN_RESET;
        state_next.watch = rmc_pkg::WATCH_RESET;
        state_next.pend = 4'h0;
        state_next.recomp = 4'h0;
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg.phase <= rmc_pkg::RMC_IDLE;
      // [R5] regions watched after reset
      state_reg.watch <= rmc_pkg::WATCH_RESET;
      state_reg.run <= rmc_pkg::RUN_RESET;
      state_reg.recomp <= 4'h0;
      state_reg.pend <= 4'h0;
      state_reg.soft_rst <= 1'b0;
      state_reg.pready <= 1'b0;
      state_reg.pslverr <= 1'b0;
      state_reg.prdata <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from flip-flops
  assign pready_o = state_reg.pready;
  assign pslverr_o = state_reg.pslverr;
  assign prdata_o = state_reg.prdata;
  assign region_watch_o = state_reg.watch;
  assign monitor_run_o = state_reg.run;
  assign digest_recompute_o = state_reg.recomp;
  assign soft_reset_o = state_reg.soft_rst;

endmodule : rmc_top

//--- dv/rmc_props.sv
// assertions for rmc_top, watching its ports only
// assumes one clock domain and an apb master that holds requests until pready
`timescale 1ns/1ps
module rmc_props (
  input wire logic core_clk_i, rst_n_i, psel_i, penable_i, pwrite_i, pready_o,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] region_watch_o, digest_recompute_o,
  input wire logic monitor_run_o, soft_reset_o
);
  logic wr; // accepted control write
  logic ow; // control write without soft reset
  assign wr = psel_i && penable_i && pwrite_i && pready_o && paddr_i == 8'h04;
  assign ow = wr && !pwdata_i[2];
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_watch_on: assert property (ow |=> (region_watch_o & $past(pwdata_i[15:12])) == $past(pwdata_i[15:12]))
    else $error("watch bit not set");
  a_watch_off: assert property (ow |=> (region_watch_o & $past(pwdata_i[11:8]) & ~$past(pwdata_i[15:12])) == 4'h0)
    else $error("watch bit not cleared");
  a_watch_hold: assert property (!wr |=> region_watch_o == $past(region_watch_o))
    else $error("watch changed without write");
  a_recomp_gate: assert property (ow |=> digest_recompute_o == ($past(pwdata_i[7:4]) & ~$past(region_watch_o)))
    else $error("recompute gating wrong");
  a_recomp_quiet: assert property (!wr |=> digest_recompute_o == 4'h0)
    else $error("stray recompute pulse");
  a_reset_watch: assert property ($rose(rst_n_i) |-> region_watch_o == 4'hF)
    else $error("regions not watched after reset");
  a_soft_rst: assert property (wr && pwdata_i[2] |=> soft_reset_o && region_watch_o == 4'hF && !monitor_run_o)
    else $error("soft reset effect wrong");
  a_run_start: assert property (ow && pwdata_i[1:0] == 2'b01 |=> monitor_run_o)
    else $error("monitor did not start");
  a_run_stop: assert property (wr && pwdata_i[1] |=> !monitor_run_o)
    else $error("monitor did not stop");
endmodule : rmc_props
bind rmc_top rmc_props rmc_props_u (.*);

//--- dv/rmc_top_tb.sv
// self-checking bench for rmc_top, driving apb directly
// assumes the rmc_top ports as declared and a one-cycle apb answer
`timescale 1ns/1ps
module rmc_top_tb;
  logic core_clk_i, rst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, monitor_run_o, soft_reset_o;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic [3:0] region_watch_o, digest_recompute_o, rc;
  logic er, sr;
  int fails, checks;
  rmc_top dut_u (.*);
  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer, then an idle edge that catches the pulses
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel_i <= 1'b1; penable_i <= 1'b0; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
    @(posedge core_clk_i) penable_i <= 1'b1;
    @(posedge core_clk_i);
    while (pready_o !== 1'b1) @(posedge core_clk_i);
    rd = prdata_o; er = pslverr_o;
    psel_i <= 1'b0; penable_i <= 1'b0;
    @(posedge core_clk_i);
    rc = digest_recompute_o; sr = soft_reset_o;
  endtask : xfer
  task automatic st(input logic [31:0] exp);
    xfer(1'b0, 8'h08, 32'h0);
    chk(rd, exp);
    chk({31'h0, er}, 32'h0);
  endtask : st
  task automatic t_watch;
    st(32'h0000000F);
    chk({28'h0, region_watch_o}, 32'hF);
    xfer(1'b1, 8'h04, 32'h00000500);
    st(32'h0000000A);
    chk({28'h0, region_watch_o}, 32'hA);
    xfer(1'b1, 8'h04, 32'h00001000);
    st(32'h0000000B);
    chk({28'h0, region_watch_o}, 32'hB);
  endtask : t_watch
  task automatic t_recomp;
    xfer(1'b1, 8'h04, 32'h000000F0);
    chk({28'h0, rc}, 32'h4);
    xfer(1'b1, 8'h04, 32'h00000110);
    chk({28'h0, rc}, 32'h0);
    st(32'h0000040A);
  endtask : t_recomp
  task automatic t_run;
    xfer(1'b1, 8'h04, 32'h00000001);
    st(32'h0000041A);
    chk({31'h0, monitor_run_o}, 32'h1);
    xfer(1'b1, 8'h04, 32'h00000003);
    st(32'h0000040A);
    chk({31'h0, monitor_run_o}, 32'h0);
    xfer(1'b1, 8'h04, 32'h00000F05);
    chk({31'h0, sr}, 32'h1);
    st(32'h0000000F);
    chk({28'h0, region_watch_o}, 32'hF);
  endtask : t_run
  task automatic t_err;
    xfer(1'b1, 8'h08, 32'h00000100);
    chk({31'h0, er}, 32'h1);
    xfer(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0);
    xfer(1'b1, 8'h0C, 32'h00000100);
    chk({31'h0, er}, 32'h1);
    st(32'h0000000F);
  endtask : t_err
  task automatic wrap_up;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    #8000;
    fails++;
    wrap_up();
  end
  initial begin
    rst_n_i = 1'b0; psel_i = 1'b0; penable_i = 1'b0; pwrite_i = 1'b0;
    paddr_i = 8'h00; pwdata_i = 32'h0; fails = 0; checks = 0;
    repeat (8) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    @(posedge core_clk_i);
    t_watch();
    t_recomp();
    t_run();
    t_err();
    wrap_up();
  end
endmodule : rmc_top_tb
